// File: dlaec_regs.sv
// Lane control and receiver gain select registers with their output decode.
//
// Operation
// - Bit 7 of lane control turns listening on at 0, off at 1; resets 0.
// - Routing code 00 lets lane config and orientation decide the sideband join.
// - Routing code 01 joins AUXn to SBU1 and AUXp to SBU2 always.
// - Routing code 10 joins AUXn to SBU2 and AUXp to SBU1 always.
// - Routing code 11 leaves both AUX lines open from both SBU pins.
// - Listening on: lane-off writes are stored but do not change lanes.
// - Lane-off bit 0 means enabled, 1 disabled; resets to 0.
// - Gain bits 7:4 set receiver two; mirror the strap when not taken.
// - Gain bits 3:0 set receiver one; mirror the strap when not taken.
// - With software take set, written bits 7:4 drive receiver two.
// - With software take set, written bits 3:0 drive receiver one.
// - Lane control resets to zero; bit 6 is read-only zero.
// - Gain select register resets to zero.
// - Software take picks strap at 0, register at 1; resets 0.
// - Listening on: only lanes named by the captured lane count run.
`timescale 1ns/1ps
`include "dlaec_defines.svh"

module dlaec_regs
  import dlaec_pkg::*;
#(
  parameter int NUM_LANES = `DLAEC_NUM_LANES
)(
  // Clock and reset.
  input  wire logic                         i_clk,
  input  wire logic                         i_rstn,
  // Register port.
  input  wire logic                         i_reg_wr,
  input  wire logic                         i_reg_rd,
  input  wire logic [`DLAEC_ADDR_W-1:0]     i_reg_addr,
  input  wire logic [`DLAEC_DATA_W-1:0]     i_reg_wdata,
  output logic      [`DLAEC_DATA_W-1:0]     o_reg_rdata,
  output logic                              o_reg_rvalid,
  // Device state inputs.
  input  wire logic                         i_lane_config_select,
  input  wire logic                         i_orientation_select,
  input  wire logic                         i_gain_software_take,
  input  wire logic [1:0]                   i_usb_gain_strap_pins,
  input  wire logic                         i_strap_sample,
  input  wire logic [`DLAEC_LANE_CNT_W-1:0] i_lane_count,
  // Controls to the datapath.
  output logic                              o_aux_listen_en,
  output dlaec_route_t                      o_sbu_route,
  output logic      [NUM_LANES-1:0]         o_lane_en,
  output dlaec_gain_t                       o_rx_gain
);

  // --------------------------------------------------------------------------
  // Reset synchroniser
  // --------------------------------------------------------------------------

  logic rst_meta_reg;
  logic rst_sync_reg;

  // Assertion is asynchronous, release passes two flip-flops.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  logic rstn;
  assign rstn = rst_sync_reg;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------

  // Register write hit at a given offset.
  function automatic logic wr_hit(input logic                     wr,
                                  input logic [`DLAEC_ADDR_W-1:0] addr,
                                  input logic [`DLAEC_ADDR_W-1:0] ofs);
    wr_hit = wr && (addr == ofs);
  endfunction

  // Route for a fixed joining: n_to_1 chooses AUXn onto SBU1, else SBU2.
  function automatic dlaec_route_t join_route(input logic n_to_1);
    dlaec_route_t r;
    r.auxn_sbu1 = n_to_1;
    r.auxp_sbu2 = n_to_1;
    r.auxn_sbu2 = !n_to_1;
    r.auxp_sbu1 = !n_to_1;
    join_route  = r;
  endfunction

  // --------------------------------------------------------------------------
  // Strap mapping
  // --------------------------------------------------------------------------

  logic [3:0] strap_gain;

  dlaec_strap_map u_strap_map (
    .i_strap (i_usb_gain_strap_pins),
    .o_gain  (strap_gain)
  );

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------

  logic [`DLAEC_DATA_W-1:0] lane_ctrl_reg;
  logic [`DLAEC_DATA_W-1:0] lane_ctrl_next;
  logic [`DLAEC_DATA_W-1:0] gain_sel_reg;
  logic [`DLAEC_DATA_W-1:0] gain_sel_next;
  logic [`DLAEC_DATA_W-1:0] rdata_reg;
  logic [`DLAEC_DATA_W-1:0] rdata_next;
  logic                     rvalid_reg;
  logic                     rvalid_next;

  // Writes, strap mirroring and read answers.
  always_comb begin
    lane_ctrl_next = lane_ctrl_reg;
    gain_sel_next  = gain_sel_reg;
    // Lane-off bits are stored whatever the listening state.
    if (wr_hit(i_reg_wr, i_reg_addr, `DLAEC_OFS_LANE_CTRL)) begin
      lane_ctrl_next = i_reg_wdata;
      lane_ctrl_next[`DLAEC_RSVD_BIT] = 1'b0;
    end
    // A software write wins over a strap sample in the same cycle.
    if (wr_hit(i_reg_wr, i_reg_addr, `DLAEC_OFS_GAIN_SEL)) begin
      gain_sel_next = i_reg_wdata;
    end else if (!i_gain_software_take && i_strap_sample) begin
      gain_sel_next[`DLAEC_RX2_HI:`DLAEC_RX2_LO] = strap_gain;
      gain_sel_next[`DLAEC_RX1_HI:`DLAEC_RX1_LO] = strap_gain;
    end
    rvalid_next = i_reg_rd;
    rdata_next  = rdata_reg;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        `DLAEC_OFS_LANE_CTRL: rdata_next = lane_ctrl_reg;
        `DLAEC_OFS_GAIN_SEL:  rdata_next = gain_sel_reg;
        default:              rdata_next = `DLAEC_ZERO8;
      endcase
    end
  end

  // Register state, cleared to the register reset values.
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      lane_ctrl_reg <= `DLAEC_LANE_CTRL_RST;
      gain_sel_reg  <= `DLAEC_GAIN_SEL_RST;
      rdata_reg     <= `DLAEC_ZERO8;
      rvalid_reg    <= 1'b0;
    end else begin
      lane_ctrl_reg <= lane_ctrl_next;
      gain_sel_reg  <= gain_sel_next;
      rdata_reg     <= rdata_next;
      rvalid_reg    <= rvalid_next;
    end
  end

  // --------------------------------------------------------------------------
  // Output decode
  // --------------------------------------------------------------------------

  logic                 listen_reg;
  logic                 listen_next;
  dlaec_route_t         route_reg;
  dlaec_route_t         route_next;
  logic [NUM_LANES-1:0] lane_en_reg;
  logic [NUM_LANES-1:0] lane_en_next;
  dlaec_gain_t          gain_reg;
  dlaec_gain_t          gain_next;
  logic [1:0]           route_code;
  logic [NUM_LANES-1:0] lane_off;

  assign route_code = lane_ctrl_reg[`DLAEC_ROUTE_HI:`DLAEC_ROUTE_LO];
  assign lane_off   = lane_ctrl_reg[`DLAEC_LANE_OFF_HI:`DLAEC_LANE_OFF_LO];

  // Next values of the datapath controls, from the stored registers and the live inputs.
  always_comb begin
    listen_next = !lane_ctrl_reg[`DLAEC_LISTEN_OFF_BIT];
    route_next  = '0;
    unique case (route_code)
      `DLAEC_ROUTE_NORMAL: begin
        // Joined only while the lane config allows sideband, side by orientation.
        if (i_lane_config_select) begin
          route_next = join_route(i_orientation_select);
        end
      end
      `DLAEC_ROUTE_N1_P2: route_next = join_route(1'b1);
      `DLAEC_ROUTE_N2_P1: route_next = join_route(1'b0);
      `DLAEC_ROUTE_OPEN:  route_next = '0;
    endcase
    for (int i = 0; i < NUM_LANES; i++) begin
      if (listen_next) begin
        lane_en_next[i] = (32'(i) < 32'(i_lane_count));
      end else begin
        lane_en_next[i] = !lane_off[i];
      end
    end
    // Without software take the applied gain follows the live strap.
    if (i_gain_software_take) begin
      gain_next.rx2 = gain_sel_reg[`DLAEC_RX2_HI:`DLAEC_RX2_LO];
      gain_next.rx1 = gain_sel_reg[`DLAEC_RX1_HI:`DLAEC_RX1_LO];
    end else begin
      gain_next.rx2 = strap_gain;
      gain_next.rx1 = strap_gain;
    end
  end

  // Output flip-flops; all outputs come from here or the register file.
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      listen_reg  <= 1'b0;
      route_reg   <= '0;
      lane_en_reg <= '0;
      gain_reg    <= '0;
    end else begin
      listen_reg  <= listen_next;
      route_reg   <= route_next;
      lane_en_reg <= lane_en_next;
      gain_reg    <= gain_next;
    end
  end

  assign o_reg_rdata     = rdata_reg;
  assign o_reg_rvalid    = rvalid_reg;
  assign o_aux_listen_en = listen_reg;
  assign o_sbu_route     = route_reg;
  assign o_lane_en       = lane_en_reg;
  assign o_rx_gain       = gain_reg;

endmodule // dlaec_regs

// File: dlaec_defines.svh
// Register offsets, field positions, reset values and strap gain table constants.
`ifndef DLAEC_DEFINES_SVH
`define DLAEC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define DLAEC_ADDR_W            8
`define DLAEC_DATA_W            8
`define DLAEC_OFS_LANE_CTRL     8'h13
`define DLAEC_OFS_GAIN_SEL      8'h20

// ----------------------------------------------------------------------------
// Lane control register layout
// ----------------------------------------------------------------------------
`define DLAEC_LISTEN_OFF_BIT    7
`define DLAEC_RSVD_BIT          6
`define DLAEC_ROUTE_HI          5
`define DLAEC_ROUTE_LO          4
`define DLAEC_LANE_OFF_HI       3
`define DLAEC_LANE_OFF_LO       0
`define DLAEC_LANE_CTRL_RST     8'h00

// ----------------------------------------------------------------------------
// Gain select register layout
// ----------------------------------------------------------------------------
`define DLAEC_RX2_HI            7
`define DLAEC_RX2_LO            4
`define DLAEC_RX1_HI            3
`define DLAEC_RX1_LO            0
`define DLAEC_GAIN_SEL_RST      8'h00

// ----------------------------------------------------------------------------
// Routing field codes and misc constants
// ----------------------------------------------------------------------------
`define DLAEC_ROUTE_NORMAL      2'h0
`define DLAEC_ROUTE_N1_P2       2'h1
`define DLAEC_ROUTE_N2_P1       2'h2
`define DLAEC_ROUTE_OPEN        2'h3
`define DLAEC_NUM_LANES         4
`define DLAEC_LANE_CNT_W        5
`define DLAEC_ZERO8             8'h00

// ----------------------------------------------------------------------------
// Fixed strap to gain table
// ----------------------------------------------------------------------------
`define DLAEC_GAIN_STRAP0       4'h0
`define DLAEC_GAIN_STRAP1       4'h5
`define DLAEC_GAIN_STRAP2       4'hA
`define DLAEC_GAIN_STRAP3       4'hF

`endif

// File: dlaec_pkg.sv
// Types shared by the lane, routing and gain control logic.
package dlaec_pkg;

  // --------------------------------------------------------------------------
  // Sideband switch closures, one bit per possible connection.
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic auxn_sbu1;
    logic auxn_sbu2;
    logic auxp_sbu1;
    logic auxp_sbu2;
  } dlaec_route_t;

  // --------------------------------------------------------------------------
  // Gain settings for the two downstream receivers.
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] rx2;
    logic [3:0] rx1;
  } dlaec_gain_t;

endpackage

// File: dlaec_strap_map.sv
// Fixed table that turns the two-bit gain strap into a four-bit gain code.
`timescale 1ns/1ps
`include "dlaec_defines.svh"

module dlaec_strap_map
  import dlaec_pkg::*;
(
  // Strap sample in.
  input  wire logic [1:0] i_strap,
  // Mapped gain code out.
  output logic      [3:0] o_gain
);

  // --------------------------------------------------------------------------
  // Lookup
  // --------------------------------------------------------------------------

  // Every strap code has an entry, so no default is needed.
  always_comb begin
    unique case (i_strap)
      2'h0: o_gain = `DLAEC_GAIN_STRAP0;
      2'h1: o_gain = `DLAEC_GAIN_STRAP1;
      2'h2: o_gain = `DLAEC_GAIN_STRAP2;
      2'h3: o_gain = `DLAEC_GAIN_STRAP3;
    endcase
  end

endmodule // dlaec_strap_map

// File: dlaec_regs_sva.sv
// Concurrent checks on the ports of the lane control and gain select block.
`timescale 1ns/1ps
`include "dlaec_defines.svh"
module dlaec_regs_sva
  import dlaec_pkg::*;
#(
  parameter int NUM_LANES = `DLAEC_NUM_LANES
)(
  // Watched ports.
  input wire logic                 i_clk,
  input wire logic                 i_rstn,
  input wire logic                 i_reg_wr,
  input wire logic                 i_reg_rd,
  input wire logic [7:0]           i_reg_addr,
  input wire logic [7:0]           i_reg_wdata,
  input wire logic [7:0]           o_reg_rdata,
  input wire logic                 o_reg_rvalid,
  input wire logic                 i_gain_software_take,
  input wire logic [1:0]           i_usb_gain_strap_pins,
  input wire logic [4:0]           i_lane_count,
  input wire logic                 o_aux_listen_en,
  input wire dlaec_route_t         o_sbu_route,
  input wire logic [NUM_LANES-1:0] o_lane_en,
  input wire dlaec_gain_t          o_rx_gain
);
  logic [3:0] cnt_mask;
  wire        wr13 = i_reg_wr && (i_reg_addr == `DLAEC_OFS_LANE_CTRL);
  wire        wr20 = i_reg_wr && (i_reg_addr == `DLAEC_OFS_GAIN_SEL);
  // Lanes that a captured count turns on.
  always_comb begin
    cnt_mask = (i_lane_count > 5'h03) ? 4'hF : 4'((5'h01 << i_lane_count) - 5'h01);
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  chk_read_pulse: assert property (o_reg_rvalid == $past(i_reg_rd))
    else $error("read valid not one cycle after read");
  chk_listen_bit: assert property (wr13 |-> ##2 o_aux_listen_en == !$past(i_reg_wdata[7], 2))
    else $error("listen enable does not follow bit 7");
  chk_route_n1p2: assert property (wr13 && i_reg_wdata[5:4] == 2'h1 |-> ##2 o_sbu_route == 4'h9)
    else $error("forced route one wrong");
  chk_route_n2p1: assert property (wr13 && i_reg_wdata[5:4] == 2'h2 |-> ##2 o_sbu_route == 4'h6)
    else $error("forced route two wrong");
  chk_route_open: assert property (wr13 && i_reg_wdata[5:4] == 2'h3 |-> ##2 o_sbu_route == 4'h0)
    else $error("open route not open");
  chk_lane_off: assert property (wr13 && i_reg_wdata[7] |-> ##2 o_lane_en == ~$past(i_reg_wdata[3:0], 2))
    else $error("lane enables do not follow off bits");
  chk_lane_count: assert property (o_aux_listen_en && !$past(i_reg_wr) |=> o_lane_en == $past(cnt_mask))
    else $error("lane enables do not follow lane count");
  chk_gain_strap: assert property (!i_gain_software_take |=> o_rx_gain == {4{$past(i_usb_gain_strap_pins)}})
    else $error("gain does not follow strap");
  chk_gain_take: assert property (wr20 && i_gain_software_take ##1 i_gain_software_take |=> o_rx_gain == $past(i_reg_wdata, 2))
    else $error("taken gain not applied");
  chk_rsvd_zero: assert property (o_reg_rvalid && $past(i_reg_addr) == 8'h13 |-> !o_reg_rdata[6])
    else $error("reserved bit reads one");
endmodule // dlaec_regs_sva

bind dlaec_regs dlaec_regs_sva #(.NUM_LANES(NUM_LANES)) dlaec_regs_sva_inst (.i_clk, .i_rstn,
  .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid,
  .i_gain_software_take, .i_usb_gain_strap_pins, .i_lane_count, .o_aux_listen_en,
  .o_sbu_route, .o_lane_en, .o_rx_gain);

// File: dlaec_host_model.sv
// Register port host that issues single-byte reads and writes.
`timescale 1ns/1ps
module dlaec_host_model (
  // Clock and read answer.
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid,
  // Request lines.
  output logic            o_wr,
  output logic            o_rd,
  output logic [7:0]      o_addr,
  output logic [7:0]      o_wdata
);
  // Idle request lines at time zero.
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  // One write; address and data are scrambled once the strobe drops.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  // One read; the answer is taken at the edge after the taking edge.
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    @(posedge i_clk);
    d = i_rvalid ? i_rdata : 8'hxx;
  endtask
endmodule // dlaec_host_model

// File: dlaec_regs_tb.sv
// Self-checking bench for the lane control and gain select registers.
`timescale 1ns/1ps
`include "dlaec_defines.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin fail_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module dlaec_regs_tb
  import dlaec_pkg::*;
;
  logic clk, rstn, cfg_sel, orient, take, sample, wr, rd, rvalid, listen;
  logic [1:0] strap;
  logic [4:0] lane_cnt;
  logic [7:0] addr, wdata, rdata;
  logic [3:0] lane_en;
  dlaec_route_t route;
  dlaec_gain_t gain;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;
  dlaec_regs dlaec_regs_inst (.i_clk(clk), .i_rstn(rstn), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_lane_config_select(cfg_sel), .i_orientation_select(orient),
    .i_gain_software_take(take), .i_usb_gain_strap_pins(strap), .i_strap_sample(sample),
    .i_lane_count(lane_cnt), .o_aux_listen_en(listen), .o_sbu_route(route),
    .o_lane_en(lane_en), .o_rx_gain(gain));
  dlaec_host_model dlaec_host_model_inst (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid),
    .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
  task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
    dlaec_host_model_inst.wr_reg(a, d);
    repeat (2) @(posedge clk);
  endtask
  task automatic rd_b(input logic [7:0] a, output logic [7:0] d);
    dlaec_host_model_inst.rd_reg(a, d);
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Reset values and an unmapped read.
  task automatic t_reset();
    logic [7:0] d;
    rd_b(8'h13, d);
    `CHK("lane_ctrl_rst", 8'h00, d)
    rd_b(8'h20, d);
    `CHK("gain_sel_rst", 8'h00, d)
    `CHK("listen_rst", 1'b1, listen)
    rd_b(8'h55, d);
    `CHK("unmapped_rd", 8'h00, d)
  endtask
  // Every routing code, with orientation set so normal routing would differ.
  task automatic t_route();
    logic [3:0] ex [4] = '{4'h9, 4'h9, 4'h6, 4'h0};
    for (int c = 0; c < 4; c++) begin
      cfg_sel <= 1'b1;
      orient <= ~c[0];
      wr_b(8'h13, {2'b10, 2'(c), 4'h0});
      `CHK("route_code", ex[c], route)
    end
    // Normal routing with the other orientation joins the crossed pair.
    orient <= 1'b0;
    wr_b(8'h13, 8'h80);
    `CHK("route_norm_flip", 4'h6, route)
    cfg_sel <= 1'b0;
    wr_b(8'h13, 8'h80);
    `CHK("route_no_cfg", 4'h0, route)
  endtask
  // Lane-off bits with listening off, then the captured count with it on.
  task automatic t_lanes();
    logic [7:0] d;
    wr_b(8'h13, 8'hFA);
    `CHK("lane_off", 4'h5, lane_en)
    `CHK("listen_off", 1'b0, listen)
    rd_b(8'h13, d);
    `CHK("rsvd_bit", 8'hBA, d)
    wr_b(8'h13, 8'h0F);
    for (int n = 0; n < 6; n++) begin
      lane_cnt <= 5'(n);
      repeat (2) @(posedge clk);
      `CHK("lane_count", (n > 3) ? 4'hF : 4'((1 << n) - 1), lane_en)
    end
    rd_b(8'h13, d);
    `CHK("lane_off_kept", 8'h0F, d)
  endtask
  // Strap mirror for each strap value, then the software value.
  task automatic t_gain();
    logic [7:0] d;
    for (int s = 0; s < 5; s++) begin
      take <= (s == 4);
      strap <= 2'(s);
      sample <= 1'b1;
      @(posedge clk);
      sample <= 1'b0;
      if (s == 4) begin
        wr_b(8'h20, 8'h3C);
      end
      rd_b(8'h20, d);
      `CHK("gain_reg", (s == 4) ? 8'h3C : {4{2'(s)}}, d)
      `CHK("gain_out", (s == 4) ? 8'h3C : {4{2'(s)}}, gain)
    end
    strap <= 2'h1;
    sample <= 1'b1;
    @(posedge clk);
    sample <= 1'b0;
    rd_b(8'h20, d);
    `CHK("gain_kept", 8'h3C, d)
  endtask
  // Clock source.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Hang guard.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      print_verdict();
    end
  end
  // Main sequence.
  initial begin
    rstn = 1'b0;
    cfg_sel = 1'b0;
    orient = 1'b0;
    take = 1'b0;
    strap = 2'h0;
    sample = 1'b0;
    lane_cnt = 5'h00;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_route();
    t_lanes();
    t_gain();
    print_verdict();
  end
endmodule // dlaec_regs_tb
